// ---- design/olc_counters.sv ----
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "olc_regs.svh"
// What this block does
// - first load gate loads instruction bits 12-15 into first counter.
// - second load gate loads instruction bits 8-11 into second counter.
// - logical instructions couple both counters, loaded from bits 8-15.
// - recirculation loads the latch value into each counter register.
// - triggers and latches follow input while released, else hold.
// - trigger release and latch release are separate inputs.
// - instruction load uses its own release; stepping uses the trigger release.
// - latch value is stable when triggers capture it.
// - latch takes register value or stepped value by count line.
// - address-computation hold blocks the latch release.
// - each nibble counter wraps modulo sixteen.
// - end of operation decoded from latches: 1110, or 1111-1110 coupled.
// - counting up, clear position sets latch, set position passes carry.
// - low position carry-in is count up OR count down, except in step by eight and in the coupled high counter.
// - counting down, carry toggles positions and passes through clear ones.
// - coupled, first counter is high nibble, second is low nibble.
// - coupled high counter steps only on low carry at 15 up or 0 down, or at 0-7 when stepping by eight.
// - coupled block move in transmit mode steps down by eight.
module olc_counters
  import olc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  // ****************************************************************
  // register bus
  // ****************************************************************
  logic [31:0] ctrl_q, ctrl_d;
  logic [15:0] instr_q, instr_d;
  logic        wr_en;
  logic        load_pulse_q, load_pulse_d;
  logic        hit;

  assign wr_en   = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign hit     = (paddr == `OLC_ADDR_CTRL) || (paddr == `OLC_ADDR_STATUS) ||
                   (paddr == `OLC_ADDR_INSTR) || (paddr == `OLC_ADDR_COUNT);
  assign pslverr = psel & penable & ~hit;

  always_comb begin
    ctrl_d       = ctrl_q;
    instr_d      = instr_q;
    load_pulse_d = 1'b0;
    if (wr_en && paddr == `OLC_ADDR_CTRL) begin
      ctrl_d = pwdata;
      load_pulse_d = pwdata[`OLC_CTRL_LOAD_FIRST] | pwdata[`OLC_CTRL_LOAD_SECOND];
    end
    if (wr_en && paddr == `OLC_ADDR_INSTR) begin
      instr_d = pwdata[15:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_q       <= `OLC_CTRL_RESET;
      instr_q      <= 16'h0000;
      load_pulse_q <= 1'b0;
    end else begin
      ctrl_q       <= ctrl_d;
      instr_q      <= instr_d;
      load_pulse_q <= load_pulse_d;
    end
  end

  // ****************************************************************
  // control lines
  // ****************************************************************
  logic load_first, load_second, recirc_first_latch, recirc_second_latch;
  logic cnt_up, cnt_dn, rel_trig, rel_latch, coupled, by_eight, addr_hold;
  logic latch_rel;
  olc_dir_type dir;

  // load gates act for one cycle after a control write that sets them
  assign load_first  = load_pulse_q & ctrl_q[`OLC_CTRL_LOAD_FIRST];
  assign load_second = load_pulse_q & ctrl_q[`OLC_CTRL_LOAD_SECOND];
  assign recirc_first_latch  = ~load_first;
  assign recirc_second_latch = ~load_second;
  assign cnt_up    = ctrl_q[`OLC_CTRL_COUNT_UP] & ~ctrl_q[`OLC_CTRL_COUNT_DOWN];
  assign cnt_dn    = ctrl_q[`OLC_CTRL_COUNT_DOWN] & ~ctrl_q[`OLC_CTRL_COUNT_UP];
  assign rel_trig  = ctrl_q[`OLC_CTRL_REL_TRIG];
  assign rel_latch = ctrl_q[`OLC_CTRL_REL_LATCH];
  assign coupled   = ctrl_q[`OLC_CTRL_COUPLED];
  assign by_eight  = coupled & cnt_dn & ctrl_q[`OLC_CTRL_BY_EIGHT];
  assign addr_hold = ctrl_q[`OLC_CTRL_ADDR_HOLD];
  assign latch_rel = rel_latch & ~addr_hold;
  assign dir = cnt_up ? OLC_DIR_UP : (cnt_dn ? OLC_DIR_DOWN : OLC_DIR_HOLD);

  // ****************************************************************
  // counter registers and latches
  // ****************************************************************
  olc_nibble_type first_q, first_d, second_q, second_d;
  olc_nibble_type first_lat_q, first_lat_d, second_lat_q, second_lat_d;
  logic           counting;
  logic           low_carry;

  olc_step_if first_if ();
  olc_step_if second_if ();

  assign counting = (dir != OLC_DIR_HOLD);
  assign low_carry = (cnt_up && second_q == 4'hF) || (cnt_dn && second_q == 4'h0);

  assign second_if.count_up   = cnt_up & ~by_eight;
  assign second_if.count_down = cnt_dn & ~by_eight;
  assign second_if.carry_in   = (cnt_up | cnt_dn) & ~by_eight;
  assign second_if.up4        = by_eight;
  assign second_if.dn4        = by_eight;
  assign second_if.reg_val    = second_q;

  assign first_if.count_up    = cnt_up;
  assign first_if.count_down  = cnt_dn;
  // coupled: high nibble steps only on carry out of the low nibble
  assign first_if.carry_in    = coupled ? (by_eight ? (cnt_dn && second_q[3] == 1'b0) : low_carry)
                                        : (cnt_up | cnt_dn);
  assign first_if.up4         = 1'b0;
  assign first_if.dn4         = 1'b0;
  assign first_if.reg_val     = first_q;

  olc_incdec u_first_step (
    .s (first_if.stepper)
  );

  olc_incdec u_second_step (
    .s (second_if.stepper)
  );

  always_comb begin
    first_d      = first_q;
    second_d     = second_q;
    first_lat_d  = first_lat_q;
    second_lat_d = second_lat_q;
    // latch follows stepped or held value only while released
    if (latch_rel) begin
      first_lat_d  = counting ? first_if.next_val : first_q;
      second_lat_d = counting ? second_if.next_val : second_q;
    end
    if (load_first) begin
      first_d = instr_q[15:12];
    end else if (recirc_first_latch && rel_trig) begin
      first_d = first_lat_q;
    end
    if (load_second) begin
      second_d = instr_q[11:8];
    end else if (recirc_second_latch && rel_trig) begin
      second_d = second_lat_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      first_q      <= 4'h0;
      second_q     <= 4'h0;
      first_lat_q  <= 4'h0;
      second_lat_q <= 4'h0;
    end else begin
      first_q      <= first_d;
      second_q     <= second_d;
      first_lat_q  <= first_lat_d;
      second_lat_q <= second_lat_d;
    end
  end

  // ****************************************************************
  // end of operation and readback
  // ****************************************************************
  logic end_first, end_second, end_coupled;
  logic [31:0] rdata_d;

  assign end_first   = (first_lat_q == `OLC_END_NIBBLE);
  assign end_second  = (second_lat_q == `OLC_END_NIBBLE);
  assign end_coupled = ({first_lat_q, second_lat_q} == `OLC_END_COUPLED);

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      `OLC_ADDR_CTRL:   rdata_d = ctrl_q;
      `OLC_ADDR_STATUS: rdata_d = {29'h0, end_coupled, end_second, end_first};
      `OLC_ADDR_INSTR:  rdata_d = {16'h0, instr_q};
      `OLC_ADDR_COUNT:  rdata_d = {16'h0, first_lat_q, second_lat_q, first_q, second_q};
      default:          rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= rdata_d;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_latch_hold_addr: assert property (@(posedge core_clk) disable iff (reset)
    addr_hold |=> $stable(first_lat_q) && $stable(second_lat_q))
    else $error("latch moved during address hold");
  a_load_first_val: assert property (@(posedge core_clk) disable iff (reset)
    load_first |=> first_q == $past(instr_q[15:12]))
    else $error("first counter not loaded");
  a_load_second_val: assert property (@(posedge core_clk) disable iff (reset)
    load_second |=> second_q == $past(instr_q[11:8]))
    else $error("second counter not loaded");
  a_trig_hold: assert property (@(posedge core_clk) disable iff (reset)
    !rel_trig && !load_first |=> $stable(first_q))
    else $error("trigger moved without release");
  a_up_step: assert property (@(posedge core_clk) disable iff (reset)
    latch_rel && cnt_up && !coupled |=> second_lat_q == 4'($past(second_q) + 4'h1))
    else $error("up step wrong");
  a_down_step: assert property (@(posedge core_clk) disable iff (reset)
    latch_rel && cnt_dn && !coupled |=> first_lat_q == 4'($past(first_q) - 4'h1))
    else $error("down step wrong");
  a_eight_step: assert property (@(posedge core_clk) disable iff (reset)
    latch_rel && by_eight |=> {first_lat_q, second_lat_q} == 8'($past({first_q, second_q}) - 8'h08))
    else $error("step by eight wrong");
  a_coupled_step: assert property (@(posedge core_clk) disable iff (reset)
    latch_rel && coupled && cnt_up |=> {first_lat_q, second_lat_q} == 8'($past({first_q, second_q}) + 8'h01))
    else $error("coupled up step wrong");
  a_retain_hold: assert property (@(posedge core_clk) disable iff (reset)
    latch_rel && !counting |=> first_lat_q == $past(first_q))
    else $error("latch did not retain register");
  a_retain_second: assert property (@(posedge core_clk) disable iff (reset)
    latch_rel && !counting |=> second_lat_q == $past(second_q))
    else $error("second latch did not retain register");
  a_second_trig_hold: assert property (@(posedge core_clk) disable iff (reset)
    !rel_trig && !load_second |=> $stable(second_q))
    else $error("second trigger moved without release");
  a_latch_shut: assert property (@(posedge core_clk) disable iff (reset)
    !latch_rel |=> $stable(first_lat_q) && $stable(second_lat_q))
    else $error("latch moved without release");
  a_down_wrap: assert property (@(posedge core_clk) disable iff (reset)
    latch_rel && cnt_dn && !coupled && first_q == 4'h0 |=> first_lat_q == 4'hF)
    else $error("down wrap wrong");
  a_up_wrap: assert property (@(posedge core_clk) disable iff (reset)
    latch_rel && cnt_up && !coupled && second_q == 4'hF |=> second_lat_q == 4'h0)
    else $error("up wrap wrong");
  a_first_toggle: assert property (@(posedge core_clk) disable iff (reset)
    latch_rel && counting && !coupled |=> first_lat_q[0] != $past(first_q[0]))
    else $error("low position did not toggle");
  a_coupled_down: assert property (@(posedge core_clk) disable iff (reset)
    latch_rel && coupled && cnt_dn && !by_eight |=> {first_lat_q, second_lat_q} == 8'($past({first_q, second_q}) - 8'h01))
    else $error("coupled down step wrong");
  a_high_waits: assert property (@(posedge core_clk) disable iff (reset)
    latch_rel && coupled && !by_eight && !(cnt_up && second_q == 4'hF) && !(cnt_dn && second_q == 4'h0)
    |=> first_lat_q == $past(first_q))
    else $error("high counter stepped without carry");
  a_by_eight_low: assert property (@(posedge core_clk) disable iff (reset)
    latch_rel && by_eight |=> second_lat_q[2:0] == $past(second_q[2:0]))
    else $error("step by eight moved low positions");
  a_eight_high: assert property (@(posedge core_clk) disable iff (reset)
    latch_rel && by_eight && second_q[3] |=> first_lat_q == $past(first_q))
    else $error("step by eight borrowed wrongly");

  // ****************************************************************
  // stepping sequences
  // ****************************************************************
  // a released count cycle: the latch steps while the trigger stays put
  sequence s_dn_latch_step;
    latch_rel && cnt_dn && !coupled && !rel_trig && !load_first;
  endsequence

  // the following released trigger edge takes the latch into the register
  sequence s_first_take;
    rel_trig && !latch_rel && !load_first;
  endsequence

  sequence s_second_take;
    rel_trig && !load_second;
  endsequence

  sequence s_first_recirc;
    rel_trig && !load_first;
  endsequence

  a_first_recirc: assert property (@(posedge core_clk) disable iff (reset)
    s_first_recirc |=> first_q == $past(first_lat_q))
    else $error("first register missed its latch");
  a_second_recirc: assert property (@(posedge core_clk) disable iff (reset)
    s_second_take |=> second_q == $past(second_lat_q))
    else $error("second register missed its latch");
  a_step_then_take: assert property (@(posedge core_clk) disable iff (reset)
    s_dn_latch_step ##1 s_first_take |=> first_q == 4'($past(first_q, 2) - 4'h1))
    else $error("step did not reach the register");
endmodule
`default_nettype wire

// ---- design/olc_incdec.sv ----
`timescale 1ns/1ps
`default_nettype none
// increment/decrement circuit between a counter register and its latch
module olc_incdec
  import olc_pkg::*;
(
  olc_step_if.stepper s
);
  logic [4:0] carry;
  logic [3:0] cup;
  logic [3:0] cdn;

  always_comb begin
    cup = {4{s.count_up}};
    cdn = {4{s.count_down}};
    // step-by-eight: position four gates carry regardless of its register
    cup[2] = s.count_up | s.up4;
    cdn[2] = s.count_down | s.dn4;
  end

  assign carry[0] = s.carry_in;

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_pos
      logic force_c;
      assign force_c = (i == 2) && (s.up4 || s.dn4);
      // up: set latch if register clear, else pass carry; down: toggle, pass if clear
      // a forced carry leaves position four itself alone and only toggles position eight
      assign s.next_val[i] = carry[i] ? ~s.reg_val[i] : s.reg_val[i];
      assign carry[i+1] = force_c ? 1'b1 :
        (carry[i] & ((cup[i] & s.reg_val[i]) | (cdn[i] & ~s.reg_val[i])));
    end
  endgenerate
endmodule
`default_nettype wire

// ---- design/olc_pkg.sv ----
package olc_pkg;
  typedef logic [3:0] olc_nibble_type;
  typedef enum logic [1:0] {
    OLC_DIR_HOLD,
    OLC_DIR_UP,
    OLC_DIR_DOWN
  } olc_dir_type;
endpackage

// ---- design/olc_regs.svh ----
`ifndef OLC_REGS_SVH
`define OLC_REGS_SVH

`define OLC_ADDR_CTRL        12'h000
`define OLC_ADDR_STATUS      12'h004
`define OLC_ADDR_INSTR       12'h008
`define OLC_ADDR_COUNT       12'h00C

`define OLC_CTRL_LOAD_FIRST  0
`define OLC_CTRL_LOAD_SECOND 1
`define OLC_CTRL_COUNT_UP    2
`define OLC_CTRL_COUNT_DOWN  3
`define OLC_CTRL_REL_TRIG    4
`define OLC_CTRL_REL_LATCH   5
`define OLC_CTRL_COUPLED     6
`define OLC_CTRL_BY_EIGHT    7
`define OLC_CTRL_ADDR_HOLD   8

`define OLC_STAT_END_FIRST   0
`define OLC_STAT_END_SECOND  1
`define OLC_STAT_END_COUPLED 2

`define OLC_CTRL_RESET       32'h0000_0000
`define OLC_END_NIBBLE       4'hE
`define OLC_END_COUPLED      8'hFE

`endif

// ---- design/olc_step_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// carries one four-position counter's controls and results
interface olc_step_if;
  import olc_pkg::*;
  logic           count_up;
  logic           count_down;
  logic           carry_in;
  logic           up4;
  logic           dn4;
  olc_nibble_type reg_val;
  olc_nibble_type next_val;
  modport owner (output count_up, count_down, carry_in, up4, dn4, reg_val, input next_val);
  modport stepper (input count_up, count_down, carry_in, up4, dn4, reg_val, output next_val);
endinterface
`default_nettype wire

// ---- testbench/olc_counters_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "olc_regs.svh"
module olc_counters_tb;
  import olc_pkg::*;
  logic        core_clk;
  logic        reset;
  logic        req;
  logic        wr;
  logic        done;
  logic        err;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic [11:0] addr;
  logic [11:0] paddr;
  logic [31:0] wd;
  logic [31:0] rd;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  int          num_errors = 0;
  int          check_count = 0;
  olc_counters dut_u (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  olc_seq_model seq_u (.core_clk(core_clk), .reset(reset), .req(req), .wr(wr), .addr(addr), .wd(wd),
    .done(done), .rd(rd), .err(err), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    req  <= 1'b1;
    wr   <= w;
    addr <= a;
    wd   <= d;
    @(posedge core_clk);
    req <= 1'b0;
    while (done !== 1'b1) begin
      @(posedge core_clk);
      n++;
      if (n > 50) begin
        num_errors++;
        stop_test();
      end
    end
  endtask
  // instruction bits reach the counters before any stepping starts
  task automatic load(input logic [3:0] f, input logic [3:0] s);
    xfer(1'b1, `OLC_ADDR_INSTR, {16'h0000, f, s, 8'h00});
    xfer(1'b1, `OLC_ADDR_CTRL, 32'h0000_0003);
    xfer(1'b1, `OLC_ADDR_CTRL, 32'h0000_0000);
  endtask
  // latch release alone, then trigger release alone: exactly one step
  task automatic step(input logic [31:0] mode);
    xfer(1'b1, `OLC_ADDR_CTRL, mode | 32'h0000_0020);
    xfer(1'b1, `OLC_ADDR_CTRL, 32'h0000_0010);
    xfer(1'b1, `OLC_ADDR_CTRL, 32'h0000_0000);
  endtask
  task automatic read_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0000_0000);
    check(rd, exp, what);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    read_chk(`OLC_ADDR_CTRL, `OLC_CTRL_RESET, "ctrl reset");
    read_chk(`OLC_ADDR_COUNT, 32'h0000_0000, "count reset");
  endtask
  task automatic t_load();
    load(4'h5, 4'hA);
    step(32'h0000_0000);
    read_chk(`OLC_ADDR_COUNT, 32'h0000_5A5A, "load halves");
  endtask
  task automatic t_down();
    load(4'h0, 4'h8);
    step(32'h0000_0008);
    read_chk(`OLC_ADDR_COUNT, 32'h0000_F7F7, "down wrap");
    load(4'h0, 4'hF);
    step(32'h0000_0008);
    read_chk(`OLC_ADDR_STATUS, 32'h0000_0006, "end decode");
  endtask
  task automatic t_up();
    load(4'hF, 4'h7);
    step(32'h0000_0004);
    read_chk(`OLC_ADDR_COUNT, 32'h0000_0808, "up carry");
  endtask
  task automatic t_hold();
    load(4'h3, 4'h3);
    step(32'h0000_0000);
    step(32'h0000_0108);
    read_chk(`OLC_ADDR_COUNT, 32'h0000_3333, "addr hold");
    load(4'h6, 4'h6);
    step(32'h0000_0000);
    xfer(1'b1, `OLC_ADDR_CTRL, 32'h0000_0028);
    xfer(1'b1, `OLC_ADDR_CTRL, 32'h0000_0000);
    read_chk(`OLC_ADDR_COUNT, 32'h0000_5566, "latch leads");
  endtask
  task automatic t_coupled();
    load(4'h1, 4'h0);
    step(32'h0000_0048);
    read_chk(`OLC_ADDR_COUNT, 32'h0000_0F0F, "coupled down");
    step(32'h0000_0044);
    read_chk(`OLC_ADDR_COUNT, 32'h0000_1010, "coupled up");
    step(32'h0000_00C8);
    read_chk(`OLC_ADDR_COUNT, 32'h0000_0808, "by eight");
  endtask
  task automatic t_regs();
    xfer(1'b1, 12'h010, 32'hFFFF_FFFF);
    check({31'h0, err}, 32'h0000_0001, "unmapped write err");
    read_chk(12'h010, 32'h0000_0000, "unmapped read");
    check({31'h0, err}, 32'h0000_0001, "unmapped read err");
    xfer(1'b1, `OLC_ADDR_STATUS, 32'h0000_0007);
    read_chk(`OLC_ADDR_STATUS, 32'h0000_0000, "status read only");
    xfer(1'b1, `OLC_ADDR_CTRL, 32'h0000_0100);
    read_chk(`OLC_ADDR_CTRL, 32'h0000_0100, "ctrl readback");
    xfer(1'b1, `OLC_ADDR_CTRL, 32'h0000_0000);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    reset = 1'b1;
    req   = 1'b0;
    wr    = 1'b0;
    addr  = 12'h000;
    wd    = 32'h0000_0000;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_load();
    t_down();
    t_up();
    t_hold();
    t_coupled();
    t_regs();
    stop_test();
  end
endmodule
`default_nettype wire

// ---- testbench/olc_seq_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "olc_regs.svh"
// ****************************************
// sequencer model: issues one apb transfer for each req pulse
// ****************************************
module olc_seq_model (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        req,
  input  wire logic        wr,
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wd,
  output logic             done,
  output logic      [31:0] rd,
  output logic             err,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  always @(posedge core_clk) begin
    done <= 1'b0;
    if (reset) begin
      psel    <= 1'b0;
      penable <= 1'b0;
      pwrite  <= 1'b0;
      paddr   <= 12'h000;
      pwdata  <= 32'h0000_0000;
      rd      <= 32'h0000_0000;
      err     <= 1'b0;
    end else if (psel && penable && pready) begin
      psel    <= 1'b0;
      penable <= 1'b0;
      rd      <= prdata;
      err     <= pslverr;
      done    <= 1'b1;
    end else if (psel) begin
      penable <= 1'b1;
    end else if (req) begin
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= addr;
      // load gates and separate releases travel as control words; recirculation is their inverse in the counter block
      pwdata <= (addr == `OLC_ADDR_CTRL && wd[3:2] == 2'b11) ? (wd & ~32'h8) : wd; // one direction only
    end
  end
endmodule
`default_nettype wire
